// ### dv/addressing_mode_decoder_test.sv
// Self-checking bench for the addressing mode decoder
`timescale 1ns/1ps
`default_nettype none
module addressing_mode_decoder_test;
  import amd_pkg::*;
  typedef struct packed {
    logic [7:0] pfx;
    logic [7:0] opc;
    amd_mode_t  mode;
    logic [2:0] len;
    logic [3:0] kind;
    logic       ill;
  } amd_case_t;

  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        start = 1'b0;
  logic [15:0] pc = 16'h0000;
  logic [7:0]  ix = 8'h00;
  logic [7:0]  iy = 8'h00;
  logic        ack;
  logic [7:0]  rdata;
  logic        rd;
  logic [15:0] addr;
  logic        busy;
  logic        done;
  amd_result_t res;
  logic [1:0]  mask;
  logic [1:0]  exp_mask = 2'h3;
  int          fail_count = 0;
  int          comparisons = 0;
  // ****************************************
  // Cases: prefix, opcode, mode, length, address kind, illegal
  // ****************************************
  amd_case_t cases [30] = '{
    '{8'h00, 8'h9D, M_INHERENT, 3'h1, 4'h0, 1'b0}, '{8'h00, 8'h83, M_INHERENT, 3'h1, 4'h0, 1'b0},
    '{8'h00, 8'h8E, M_INHERENT, 3'h1, 4'h0, 1'b0}, '{8'h00, 8'h8F, M_INHERENT, 3'h1, 4'h0, 1'b0},
    '{8'h00, 8'h80, M_INHERENT, 3'h1, 4'h0, 1'b0}, '{8'h00, 8'h9B, M_INHERENT, 3'h1, 4'h0, 1'b0},
    '{8'h00, 8'h9A, M_INHERENT, 3'h1, 4'h0, 1'b0}, '{8'h00, 8'h48, M_INHERENT, 3'h1, 4'h0, 1'b0},
    '{8'h00, 8'hA6, M_IMMEDIATE, 3'h2, 4'h0, 1'b0}, '{8'h00, 8'hB6, M_DIR_SHORT, 3'h2, 4'h1, 1'b0},
    '{8'h00, 8'hC6, M_DIR_LONG, 3'h3, 4'h2, 1'b0}, '{8'h00, 8'hF6, M_IDX_NONE, 3'h1, 4'h3, 1'b0},
    '{8'h00, 8'hE6, M_IDX_SHORT, 3'h2, 4'h4, 1'b0}, '{8'h00, 8'hD6, M_IDX_LONG, 3'h3, 4'h5, 1'b0},
    '{8'h92, 8'hB6, M_IND_SHORT, 3'h3, 4'h6, 1'b0}, '{8'h92, 8'hC6, M_IND_LONG, 3'h3, 4'h7, 1'b0},
    '{8'h92, 8'hE6, M_INDIDX_SHORT, 3'h3, 4'h8, 1'b0},
    '{8'h92, 8'hD6, M_INDIDX_LONG, 3'h3, 4'h9, 1'b0},
    '{8'h91, 8'hE6, M_INDIDX_SHORT, 3'h3, 4'h8, 1'b0},
    '{8'h90, 8'hE6, M_IDX_SHORT, 3'h3, 4'h4, 1'b0}, '{8'h00, 8'h20, M_REL_DIR, 3'h2, 4'hA, 1'b0},
    '{8'h92, 8'h20, M_REL_IND, 3'h3, 4'hB, 1'b0}, '{8'h00, 8'hCD, M_DIR_LONG, 3'h3, 4'h0, 1'b1},
    '{8'h00, 8'h10, M_BIT_DIR, 3'h2, 4'h1, 1'b0}, '{8'h92, 8'h10, M_BIT_IND, 3'h3, 4'h6, 1'b0},
    '{8'h00, 8'h00, M_BITREL_DIR, 3'h3, 4'hC, 1'b0},
    '{8'h92, 8'h00, M_BITREL_IND, 3'h4, 4'hD, 1'b0},
    '{8'h00, 8'hAD, M_REL_DIR, 3'h2, 4'hA, 1'b0}, '{8'h90, 8'hA6, M_IMMEDIATE, 3'h3, 4'h0, 1'b0},
    '{8'h90, 8'h90, M_INHERENT, 3'h2, 4'h0, 1'b1}
  };

  always #2.5 clk = ~clk;

  amd_addr_decoder dut (
    .i_clock(clk), .i_resetn(rstn), .i_start(start), .i_pc(pc), .i_index_x(ix),
    .i_index_y(iy), .i_mem_ack(ack), .i_mem_data(rdata), .o_mem_rd(rd), .o_mem_addr(addr),
    .o_busy(busy), .o_done(done), .o_result(res), .o_mask_level(mask)
  );
  amd_mem_model mdl (
    .i_clock(clk), .i_resetn(rstn), .i_rd(rd), .i_addr(addr), .o_ack(ack), .o_data(rdata)
  );

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Expected group of each legal opcode that the case table uses
  function automatic amd_group_t exp_group(input logic [7:0] op);
    case (op)
      8'h80, 8'h83, 8'h8E, 8'h8F: return G_IRQ;
      8'h9A, 8'h9B: return G_FLAG;
      8'h48: return G_SHIFT;
      8'h10: return G_BIT;
      8'h00: return G_BITBRANCH;
      8'h9D, 8'h20, 8'hAD: return G_JUMP;
      default: return G_LOAD;
    endcase
  endfunction
  // ****************************************
  // One decode: fill memory, start, wait, compare
  // ****************************************
  task automatic run(input amd_case_t c, input logic [7:0] b1, b2, ph, pl, x, y,
                     input logic [15:0] p);
    logic [15:0] a;
    logic [15:0] ea;
    logic [15:0] tgt;
    logic [15:0] idx;
    int          n;
    a = p;
    if (c.pfx != 8'h00) begin
      mdl.mem[a] = c.pfx;
      a++;
    end
    mdl.mem[a] = c.opc;
    mdl.mem[16'(a + 16'h0001)] = b1;
    mdl.mem[16'(a + 16'h0002)] = b2;
    mdl.mem[{8'h00, b1}] = ph;
    mdl.mem[16'({8'h00, b1} + 16'h0001)] = pl;
    idx = 16'((c.pfx == 8'h90 || c.pfx == 8'h91) ? y : x);
    case (c.kind)
      4'h1, 4'hC: ea = {8'h00, b1};
      4'h2: ea = {b1, b2};
      4'h3: ea = idx;
      4'h4: ea = idx + 16'(b1);
      4'h5: ea = {b1, b2} + idx;
      4'h6, 4'hD: ea = {8'h00, ph};
      4'h7: ea = {ph, pl};
      4'h8: ea = idx + 16'(ph);
      4'h9: ea = {ph, pl} + idx;
      default: ea = 16'h0000;
    endcase
    tgt = p + 16'(c.len);
    if (c.kind == 4'hA) tgt = tgt + {{8{b1[7]}}, b1};
    if (c.kind == 4'hB) tgt = tgt + {{8{ph[7]}}, ph};
    // Bit-relative offset is the byte after the address byte
    if (c.kind >= 4'hC) tgt = tgt + {{8{b2[7]}}, b2};
    if (c.pfx == 8'h00 && c.opc == 8'h9B) exp_mask = 2'h3;
    if (c.pfx == 8'h00 && c.opc == 8'h9A) exp_mask = 2'h0;
    @(posedge clk);
    pc <= p;
    ix <= x;
    iy <= y;
    // Held over a second edge on purpose: the busy decoder must ignore it
    start <= 1'b1;
    repeat (2) @(posedge clk);
    start <= 1'b0;
    for (n = 0; n < 80 && done !== 1'b1; n++) @(negedge clk);
    if (n == 80) begin
      fail_count++;
      end_sim;
    end
    chk("illegal", 16'(c.ill), 16'(res.illegal));
    if (!c.ill) begin
      chk("length", 16'(c.len), 16'(res.len));
      chk("mode", 16'(c.mode), 16'(res.mode));
      chk("group", 16'(exp_group(c.opc)), 16'(res.group));
      chk("bytes", {c.pfx, c.opc}, {res.prefix, res.opcode});
      chk("address", ea, res.ea);
      chk("target", tgt, res.target);
      chk("operand", (c.mode == M_IMMEDIATE) ? 16'(b1) : 16'h0000, 16'(res.operand));
      chk("use_y", 16'(c.pfx == 8'h90 || c.pfx == 8'h91), 16'(res.use_y));
      chk("flags", 16'({c.pfx == 8'h00 && c.opc == 8'h83, c.pfx == 8'h00 && c.opc == 8'h8F,
                        c.pfx == 8'h00 && c.opc == 8'h8E, c.pfx == 8'h00 && c.opc == 8'h80}),
          16'({res.sw_trap, res.wait_irq, res.halt_osc, res.irq_exit}));
      chk("mask", 16'(exp_mask), 16'(mask));
    end
  endtask
  // ****************************************
  // Main sequence; first pass sets b1, ph, X and Y to FF
  // ****************************************
  initial begin
    logic [7:0] b;
    void'($urandom(32'h0000_fd89));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    chk("reset", 16'h0003, {12'h000, busy, done, mask});
    for (int pass = 0; pass < 6; pass++) begin
      foreach (cases[i]) begin
        b = (pass == 0) ? 8'hFF : 8'($urandom);
        run(cases[i], b, 8'($urandom), b, 8'($urandom), b, (pass == 0) ? b : 8'($urandom),
            16'h1000 + 16'($urandom_range(32'h0000_DFFF, 0)));
      end
    end
    end_sim;
  end
endmodule
`default_nettype wire

// ### dv/amd_mem_model.sv
// Program and data memory model answering the decoder's byte reads
`timescale 1ns/1ps
`default_nettype none
module amd_mem_model (
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_rd,
  input  wire logic [15:0] i_addr,
  output logic             o_ack,
  output logic [7:0]       o_data
);
  // ****************************************
  // Storage, filled by the bench
  // ****************************************
  logic [7:0] mem [0:65535];
  logic [1:0] wait_cnt;

  // ****************************************
  // Answer after one to three cycles
  // ****************************************
  // Data toggles outside the ack cycle so a byte taken one cycle late never looks right
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_ack    <= 1'b0;
      o_data   <= 8'h00;
      wait_cnt <= 2'h0;
    end else if (o_ack) begin
      o_ack    <= 1'b0;
      o_data   <= ~o_data;
      wait_cnt <= 2'($urandom_range(2, 0));
    end else if (i_rd && wait_cnt == 2'h0) begin
      o_ack  <= 1'b1;
      o_data <= mem[i_addr];
    end else begin
      o_data <= ~o_data;
      if (i_rd) begin
        wait_cnt <= wait_cnt - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/amd_addr_decoder.sv
// Instruction length and effective address generator
`timescale 1ns/1ps
`default_nettype none
`include "amd_defines.svh"
module amd_addr_decoder
  import amd_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_start,
  input  wire logic [15:0] i_pc,
  input  wire logic [7:0]  i_index_x,
  input  wire logic [7:0]  i_index_y,
  input  wire logic        i_mem_ack,
  input  wire logic [7:0]  i_mem_data,
  output logic             o_mem_rd,
  output logic [15:0]      o_mem_addr,
  output logic             o_busy,
  output logic             o_done,
  output amd_result_t      o_result,
  output logic [1:0]       o_mask_level
);
  // ****************************************
  // State
  // ****************************************
  amd_state_t  state;
  amd_state_t  next_state;
  amd_mode_t   mode;
  amd_mode_t   next_mode;
  amd_attr_t   attr;
  amd_attr_t   next_attr;
  amd_group_t  group;
  logic [15:0] pc;
  logic [15:0] pc_start;
  logic [7:0]  prefix;
  logic [7:0]  opcode;
  logic [7:0]  b1;
  logic [7:0]  b2;
  logic [15:0] ptr;
  logic [7:0]  roff;
  logic        bad;
  logic        next_bad;
  logic        is_pfx;
  logic        take;
  logic        fetching;
  logic [15:0] next_addr;
  logic [15:0] base;
  logic [15:0] next_ea;
  logic [7:0]  rel_off;
  logic [15:0] next_target;
  logic [7:0]  idx;
  logic        o_result_use_y_w;

  function automatic amd_attr_t mode_attr(input amd_mode_t m);
    amd_attr_t a;
    a = '0;
    case (m)
      M_IMMEDIATE, M_DIR_SHORT, M_IDX_SHORT, M_REL_DIR, M_BIT_DIR: a.n_after = 2'd1;
      M_DIR_LONG, M_IDX_LONG: a.n_after = 2'd2;
      M_IND_SHORT, M_INDIDX_SHORT, M_REL_IND, M_BIT_IND: begin
        a.n_after = 2'd1;
        a.ind = 1'b1;
      end
      M_IND_LONG, M_INDIDX_LONG: begin
        a.n_after = 2'd1;
        a.ind = 1'b1;
        a.wptr = 1'b1;
      end
      M_BITREL_DIR: begin
        a.n_after = 2'd1;
        a.roff = 1'b1;
      end
      M_BITREL_IND: begin
        a.n_after = 2'd1;
        a.ind = 1'b1;
        a.roff = 1'b1;
      end
      default: a = '0;
    endcase
    a.idxd = (m == M_IDX_NONE) || (m == M_IDX_SHORT) || (m == M_IDX_LONG) ||
             (m == M_INDIDX_SHORT) || (m == M_INDIDX_LONG);
    return a;
  endfunction

  // Classes whose operations only exist in short memory forms
  function automatic logic short_only(input logic [7:0] op);
    logic [3:0] c;
    c = op[7:4];
    return (c == `AMD_CLS_BTJ) || (c == `AMD_CLS_BIT) || (c == `AMD_CLS_RMD) ||
           (c == `AMD_CLS_RM1) || (c == `AMD_CLS_RM0) ||
           ((c >= `AMD_CLS_IMM) && (op[3:0] == `AMD_LO_JUMP || op[3:0] == `AMD_LO_CALL));
  endfunction

  amd_group_classify u_group (
    .i_opcode (opcode),
    .o_group  (group)
  );

  assign take = o_mem_rd && i_mem_ack;
  assign attr = mode_attr(mode);
  assign next_attr = mode_attr(next_mode);
  assign idx = o_result_use_y_w ? i_index_y : i_index_x;
  assign is_pfx = (i_mem_data == `AMD_PFX_Y) || (i_mem_data == `AMD_PFX_IY) ||
                  (i_mem_data == `AMD_PFX_IND);

  // ****************************************
  // Opcode decode from the byte on the bus
  // ****************************************
  always_comb begin
    logic [3:0] c;
    logic ind;
    logic ok_y;
    logic ok_ind;
    logic ok_iy;
    logic relcall;
    c = i_mem_data[7:4];
    ind = (prefix == `AMD_PFX_IND) || (prefix == `AMD_PFX_IY);
    relcall = (c == `AMD_CLS_IMM) && (i_mem_data[3:0] == `AMD_LO_CALL);
    ok_y = 1'b1;
    ok_ind = 1'b0;
    ok_iy = 1'b0;
    next_bad = 1'b0;
    case (c)  // RULE_20
      `AMD_CLS_BTJ: begin
        next_mode = ind ? M_BITREL_IND : M_BITREL_DIR;  // RULE_15
        ok_y = 1'b0;
        ok_ind = 1'b1;
      end
      `AMD_CLS_BIT: begin
        next_mode = ind ? M_BIT_IND : M_BIT_DIR;
        ok_y = 1'b0;
        ok_ind = 1'b1;
      end
      `AMD_CLS_REL: begin
        next_mode = ind ? M_REL_IND : M_REL_DIR;  // RULE_15
        ok_y = 1'b0;
        ok_ind = 1'b1;
      end
      `AMD_CLS_RMD, `AMD_CLS_DIR: begin
        next_mode = ind ? M_IND_SHORT : M_DIR_SHORT;  // RULE_03
        ok_ind = 1'b1;
      end
      `AMD_CLS_EXT: begin
        next_mode = ind ? M_IND_LONG : M_DIR_LONG;  // RULE_04
        ok_ind = 1'b1;
        next_bad = short_only(i_mem_data);  // RULE_13
      end
      `AMD_CLS_IX2: begin
        next_mode = ind ? M_INDIDX_LONG : M_IDX_LONG;  // RULE_08
        ok_ind = 1'b1;
        ok_iy = 1'b1;
        next_bad = short_only(i_mem_data);  // RULE_13
      end
      `AMD_CLS_RM1, `AMD_CLS_IX1: begin
        next_mode = ind ? M_INDIDX_SHORT : M_IDX_SHORT;  // RULE_07
        ok_ind = 1'b1;
        ok_iy = 1'b1;
      end
      `AMD_CLS_RM0, `AMD_CLS_IX0: next_mode = M_IDX_NONE;  // RULE_06
      `AMD_CLS_IMM: begin
        next_mode = relcall ? (ind ? M_REL_IND : M_REL_DIR) : M_IMMEDIATE;  // RULE_02
        ok_ind = relcall;
        ok_y = !relcall;
      end
      default: next_mode = M_INHERENT;  // RULE_01
    endcase
    if ((prefix == `AMD_PFX_Y && !ok_y) || (prefix == `AMD_PFX_IND && !ok_ind) ||
        (prefix == `AMD_PFX_IY && !ok_iy)) begin  // RULE_19
      next_bad = 1'b1;  // RULE_21
    end
  end

  // ****************************************
  // Sequencing
  // ****************************************
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: next_state = i_start ? S_OPC : S_IDLE;
      S_OPC: begin
        if (is_pfx && prefix == `AMD_PFX_NONE) begin
          next_state = S_OPC;
        end else if (is_pfx || next_bad || next_attr.n_after == 2'd0) begin
          next_state = S_DONE;
        end else begin
          next_state = S_B1;
        end
      end
      S_B1: begin
        if (attr.n_after == 2'd2) begin
          next_state = S_B2;
        end else if (attr.ind) begin
          next_state = S_PH;
        end else begin
          next_state = attr.roff ? S_ROFF : S_DONE;
        end
      end
      S_B2: next_state = S_DONE;
      S_PH: next_state = attr.wptr ? S_PL : (attr.roff ? S_ROFF : S_DONE);
      S_PL: next_state = S_DONE;
      S_ROFF: next_state = S_DONE;
      S_DONE: next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      state <= S_IDLE;
    end else if (state == S_IDLE || state == S_DONE || take) begin
      state <= next_state;
    end
  end

  // ****************************************
  // Memory port: one byte per request, held until acknowledged
  // ****************************************
  assign fetching = (state != S_IDLE) && (state != S_DONE);
  always_comb begin
    case (state)
      S_PH: next_addr = {8'h00, b1};
      S_PL: next_addr = {8'h00, b1} + 16'h0001;
      default: next_addr = pc;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_mem_rd <= 1'b0;
      o_mem_addr <= 16'h0000;
    end else if (take) begin
      o_mem_rd <= 1'b0;
    end else if (!o_mem_rd && fetching) begin
      o_mem_rd <= 1'b1;
      o_mem_addr <= next_addr;
    end
  end

  // ****************************************
  // Byte capture
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      pc <= 16'h0000;
      pc_start <= 16'h0000;
      prefix <= `AMD_PFX_NONE;
      opcode <= 8'h00;
      mode <= M_INHERENT;
      bad <= 1'b0;
      b1 <= 8'h00;
      b2 <= 8'h00;
      ptr <= 16'h0000;
      roff <= 8'h00;
    end else if (state == S_IDLE && i_start) begin
      pc <= i_pc;
      pc_start <= i_pc;
      prefix <= `AMD_PFX_NONE;
      bad <= 1'b0;
      b1 <= 8'h00;
      b2 <= 8'h00;
      ptr <= 16'h0000;
      roff <= 8'h00;
    end else if (take) begin
      if (state != S_PH && state != S_PL) begin
        pc <= pc + 16'h0001;
      end
      case (state)
        S_OPC: begin
          if (is_pfx && prefix == `AMD_PFX_NONE) begin
            prefix <= i_mem_data;
          end else begin
            opcode <= i_mem_data;
            mode <= next_mode;
            bad <= next_bad || is_pfx;
          end
        end
        S_B1: b1 <= i_mem_data;
        S_B2: b2 <= i_mem_data;
        S_PH: ptr <= attr.wptr ? {i_mem_data, 8'h00} : {8'h00, i_mem_data};  // RULE_09 RULE_22
        S_PL: ptr[7:0] <= i_mem_data;  // RULE_22
        S_ROFF: roff <= i_mem_data;
        default: roff <= roff;
      endcase
    end
  end

  // ****************************************
  // Address and branch target
  // ****************************************
  assign o_result_use_y_w = (prefix == `AMD_PFX_Y) || (prefix == `AMD_PFX_IY);
  always_comb begin
    if (attr.ind) begin
      base = ptr;  // RULE_10
    end else if (attr.n_after == 2'd2) begin
      base = {b1, b2};  // RULE_22
    end else if (mode == M_IDX_NONE) begin
      base = 16'h0000;
    end else begin
      base = {8'h00, b1};
    end
    // Unsigned sum keeps 1FE reachable from byte operands
    next_ea = attr.idxd ? base + {8'h00, idx} : base;  // RULE_05
    if (mode == M_INHERENT || mode == M_IMMEDIATE || mode == M_REL_DIR ||
        mode == M_REL_IND) begin
      next_ea = 16'h0000;
    end
    case (mode)
      M_REL_DIR: rel_off = b1;
      M_REL_IND: rel_off = ptr[7:0];
      default: rel_off = roff;
    endcase
    next_target = pc;
    if (mode == M_REL_DIR || mode == M_REL_IND || attr.roff) begin
      next_target = pc + {{8{rel_off[7]}}, rel_off};  // RULE_14
    end
  end

  // ****************************************
  // Result
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_done <= 1'b0;
      o_busy <= 1'b0;
      o_result <= '0;
    end else begin
      o_done <= (state == S_DONE);
      o_busy <= (next_state != S_IDLE) && (state != S_DONE) &&
                (state != S_IDLE || i_start);
      if (state == S_DONE) begin
        o_result.mode <= mode;
        o_result.group <= group;  // RULE_16
        o_result.prefix <= prefix;
        o_result.opcode <= opcode;
        o_result.len <= 3'(pc - pc_start);
        o_result.ea <= next_ea;  // RULE_11
        o_result.operand <= (mode == M_IMMEDIATE) ? b1 : 8'h00;  // RULE_02
        o_result.target <= next_target;
        o_result.use_y <= o_result_use_y_w;  // RULE_19
        o_result.illegal <= bad;  // RULE_12
        o_result.sw_trap <= !bad && opcode == `AMD_OP_TRAP;  // RULE_17
        o_result.wait_irq <= !bad && opcode == `AMD_OP_WFI;
        o_result.halt_osc <= !bad && opcode == `AMD_OP_HALT;
        o_result.irq_exit <= !bad && opcode == `AMD_OP_INTERRUPT_EXIT;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_mask_level <= `AMD_MASK_ALL;
    end else if (state == S_DONE && !bad && prefix == `AMD_PFX_NONE) begin
      if (opcode == `AMD_OP_SIM) begin
        o_mask_level <= `AMD_MASK_ALL;  // RULE_18
      end else if (opcode == `AMD_OP_RIM) begin
        o_mask_level <= `AMD_MASK_OFF;  // RULE_18
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);

  chk_inherent_len: assert property ( // RULE_01
    o_done && o_result.mode == M_INHERENT && !o_result.illegal |->
    o_result.len == ((o_result.prefix == 8'h00) ? 3'd1 : 3'd2))
    else $error("inherent length wrong");
  chk_immediate_len: assert property ( // RULE_02
    o_done && o_result.mode == M_IMMEDIATE && !o_result.illegal |->
    o_result.len == ((o_result.prefix == 8'h00) ? 3'd2 : 3'd3))
    else $error("immediate length wrong");
  chk_dir_short: assert property ( // RULE_03
    o_done && (o_result.mode == M_DIR_SHORT || o_result.mode == M_IND_SHORT) |->
    o_result.ea[15:8] == 8'h00)
    else $error("short address above FF");
  chk_long_len: assert property ( // RULE_04
    o_done && !o_result.illegal && o_result.mode == M_DIR_LONG |->
    o_result.len == ((o_result.prefix == 8'h00) ? 3'd3 : 3'd4))
    else $error("long direct length wrong");
  chk_short_idx: assert property ( // RULE_07
    o_done && (o_result.mode == M_IDX_SHORT || o_result.mode == M_INDIDX_SHORT) |->
    o_result.ea <= 16'h01FE)
    else $error("short indexed beyond 1FE");
  chk_short_only: assert property ( // RULE_13
    (state == S_OPC) && take && !is_pfx && short_only(i_mem_data) &&
    (i_mem_data[7:4] == `AMD_CLS_EXT || i_mem_data[7:4] == `AMD_CLS_IX2)
    |-> ##2 o_done && o_result.illegal)
    else $error("long form of short-only accepted");
  chk_rel_target: assert property ( // RULE_14
    state == S_DONE && mode == M_REL_DIR |=>
    o_result.target == $past(pc) + {{8{$past(b1[7])}}, $past(b1)})
    else $error("relative target wrong");
  chk_mask_level: assert property ( // RULE_18
    state == S_DONE && !bad && prefix == 8'h00 && opcode == `AMD_OP_SIM |=>
    o_mask_level == 2'h3 ##1 o_mask_level == 2'h3 || o_done)
    else $error("mask not at level 3");
  chk_y_prefix: assert property ( // RULE_19
    o_done && !o_result.illegal && o_result.prefix == 8'h90 |-> o_result.use_y)
    else $error("Y prefix ignored");
  chk_read_hold: assert property ( // RULE_22
    o_mem_rd && !i_mem_ack |=> o_mem_rd && $stable(o_mem_addr))
    else $error("read request dropped");

  cov_rel_ind: cover property (o_done && o_result.mode == M_REL_IND);
  cov_long_indidx: cover property (o_done && o_result.mode == M_INDIDX_LONG);
  cov_bitrel_ind: cover property (o_done && o_result.mode == M_BITREL_IND);
  cov_illegal: cover property (o_done && o_result.illegal);
endmodule
`default_nettype wire

// ### rtl/amd_defines.svh
// Constants for the addressing mode decoder
// Summary of operation
// RULE_01: Inherent opcodes are one byte; no operand byte is fetched.
// RULE_02: Immediate instructions are two bytes; operand is the byte after opcode.
// RULE_03: Short direct fetches one address byte; operand lies in 00 to FF.
// RULE_04: Long direct fetches a two-byte address word covering all 64 Kbytes.
// RULE_05: Indexed address is unsigned sum of X or Y and the offset.
// RULE_06: No-offset indexed fetches nothing more; address is the index, 00 to FF.
// RULE_07: Short indexed adds one offset byte to the index, reaching up to 1FE.
// RULE_08: Long indexed adds a two-byte offset word to the index, whole space.
// RULE_09: Short indirect reads a byte pointer at the byte address; 00 to FF.
// RULE_10: Long indirect reads a word pointer at the byte address; whole space.
// RULE_11: Indirect indexed adds pointer to X or Y; byte to 1FE, word anywhere.
// RULE_12: Accumulator operations accept both short and long memory forms.
// RULE_13: Read-modify-write, bit, call and jump operations accept short forms only.
// RULE_14: Relative mode adds an 8-bit two's-complement offset to the PC.
// RULE_15: Direct relative offset follows opcode; indirect one is read from memory.
// RULE_16: Opcodes are classed into the thirteen instruction groups.
// RULE_17: Software trap, wait, halt and interrupt exit are flagged to the core.
// RULE_18: Mask-all sets interrupt mask level 3; unmask sets level 0.
// RULE_19: Prefix 90 swaps X for Y in immediate, direct, indexed, inherent modes.
// RULE_20: Prefix 92 turns direct and X indexed modes into indirect forms.
// RULE_21: Prefix 91 turns X indirect indexed into Y indirect indexed.
// RULE_22: Two-byte words are assembled most significant byte first.
`ifndef AMD_DEFINES_SVH
`define AMD_DEFINES_SVH
// ****************************************
// Prefix bytes
// ****************************************
`define AMD_PFX_NONE 8'h00
`define AMD_PFX_Y    8'h90
`define AMD_PFX_IY   8'h91
`define AMD_PFX_IND  8'h92
// ****************************************
// Opcode classes (high nibble) and jump/call low nibbles
// ****************************************
`define AMD_CLS_BTJ  4'h0
`define AMD_CLS_BIT  4'h1
`define AMD_CLS_REL  4'h2
`define AMD_CLS_RMD  4'h3
`define AMD_CLS_INA  4'h4
`define AMD_CLS_INX  4'h5
`define AMD_CLS_RM1  4'h6
`define AMD_CLS_RM0  4'h7
`define AMD_CLS_IN8  4'h8
`define AMD_CLS_IN9  4'h9
`define AMD_CLS_IMM  4'hA
`define AMD_CLS_DIR  4'hB
`define AMD_CLS_EXT  4'hC
`define AMD_CLS_IX2  4'hD
`define AMD_CLS_IX1  4'hE
`define AMD_CLS_IX0  4'hF
`define AMD_LO_JUMP  4'hC
`define AMD_LO_CALL  4'hD
// ****************************************
// Special inherent opcodes and interrupt mask levels
// ****************************************
`define AMD_OP_INTERRUPT_EXIT  8'h80
`define AMD_OP_RET   8'h81
`define AMD_OP_TRAP  8'h83
`define AMD_OP_HALT  8'h8E
`define AMD_OP_WFI   8'h8F
`define AMD_OP_RCF   8'h98
`define AMD_OP_SCF   8'h99
`define AMD_OP_RIM   8'h9A
`define AMD_OP_SIM   8'h9B
`define AMD_OP_RSP   8'h9C
`define AMD_OP_NOP   8'h9D
`define AMD_MASK_ALL 2'h3
`define AMD_MASK_OFF 2'h0
`endif

// ### rtl/amd_group_classify.sv
// Opcode to instruction group classifier
`timescale 1ns/1ps
`default_nettype none
`include "amd_defines.svh"
module amd_group_classify
  import amd_pkg::*;
(
  input  wire logic [7:0] i_opcode,
  output amd_group_t      o_group
);
  logic [3:0] lo;
  assign lo = i_opcode[3:0];

  always_comb begin
    o_group = G_LOAD;
    case (i_opcode[7:4])  // RULE_16
      `AMD_CLS_BTJ: o_group = G_BITBRANCH;
      `AMD_CLS_BIT: o_group = G_BIT;
      `AMD_CLS_REL: o_group = (lo <= 4'h1) ? G_JUMP : G_BRANCH;
      `AMD_CLS_RMD, `AMD_CLS_INA, `AMD_CLS_INX, `AMD_CLS_RM1, `AMD_CLS_RM0: begin
        case (lo)
          4'h0, 4'h3: o_group = G_LOGIC;
          4'h2: o_group = G_ARITH;
          4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hE: o_group = G_SHIFT;
          4'hA, 4'hC: o_group = G_INCDEC;
          4'hD: o_group = G_COMPARE;
          default: o_group = G_LOAD;
        endcase
      end
      `AMD_CLS_IN8: begin
        case (i_opcode)
          `AMD_OP_INTERRUPT_EXIT, `AMD_OP_TRAP, `AMD_OP_HALT, `AMD_OP_WFI: o_group = G_IRQ;
          `AMD_OP_RET: o_group = G_JUMP;
          default: o_group = G_STACK;
        endcase
      end
      `AMD_CLS_IN9: begin
        case (i_opcode)
          `AMD_OP_RCF, `AMD_OP_SCF, `AMD_OP_RIM, `AMD_OP_SIM: o_group = G_FLAG;
          `AMD_OP_RSP: o_group = G_STACK;
          `AMD_OP_NOP: o_group = G_JUMP;
          default: o_group = G_LOAD;
        endcase
      end
      default: begin
        case (lo)
          4'h0, 4'h2, 4'h9, 4'hB: o_group = G_ARITH;
          4'h1, 4'h3, 4'h5: o_group = G_COMPARE;
          4'h4, 4'h8, 4'hA: o_group = G_LOGIC;
          `AMD_LO_JUMP, `AMD_LO_CALL: o_group = G_JUMP;
          default: o_group = G_LOAD;
        endcase
      end
    endcase
  end
endmodule
`default_nettype wire

// ### rtl/amd_pkg.sv
// Types shared by the addressing mode decoder
package amd_pkg;
  typedef enum logic [4:0] {
    M_INHERENT, M_IMMEDIATE, M_DIR_SHORT, M_DIR_LONG, M_IDX_NONE, M_IDX_SHORT,
    M_IDX_LONG, M_IND_SHORT, M_IND_LONG, M_INDIDX_SHORT, M_INDIDX_LONG,
    M_REL_DIR, M_REL_IND, M_BIT_DIR, M_BIT_IND, M_BITREL_DIR, M_BITREL_IND
  } amd_mode_t;

  typedef enum logic [3:0] {
    G_LOAD, G_STACK, G_INCDEC, G_COMPARE, G_LOGIC, G_BIT, G_BITBRANCH,
    G_ARITH, G_SHIFT, G_JUMP, G_BRANCH, G_IRQ, G_FLAG
  } amd_group_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_OPC = 3'b001, S_B1 = 3'b011, S_B2 = 3'b010,
    S_PH = 3'b110, S_PL = 3'b111, S_ROFF = 3'b101, S_DONE = 3'b100
  } amd_state_t;

  typedef struct packed {
    logic [1:0] n_after;
    logic       ind;
    logic       wptr;
    logic       idxd;
    logic       roff;
  } amd_attr_t;

  typedef struct packed {
    amd_mode_t  mode;
    amd_group_t group;
    logic [7:0] prefix;
    logic [7:0] opcode;
    logic [2:0] len;
    logic [15:0] ea;
    logic [7:0] operand;
    logic [15:0] target;
    logic       use_y;
    logic       illegal;
    logic       sw_trap;
    logic       wait_irq;
    logic       halt_osc;
    logic       irq_exit;
  } amd_result_t;
endpackage
